// >>> asq_pkg.sv
// constants, mode codes and carrier types for the scan sequencer
package asq_pkg;
   localparam logic [7:0] ADDR_CMD       = 8'h00;
   localparam logic [7:0] ADDR_LIST_LO   = 8'h04;
   localparam logic [7:0] ADDR_LIST_HI   = 8'h08;
   localparam logic [7:0] ADDR_CFG       = 8'h0C;
   localparam logic [7:0] ADDR_SEQ_LEN   = 8'h10;
   localparam logic [7:0] ADDR_SEQ_ENTRY = 8'h14;
   localparam logic [7:0] ADDR_STATUS    = 8'h18;

   localparam int CMD_SEL_BIT   = 15;
   localparam int SCAN_LSB      = 11;
   localparam int CHSEL_LSB     = 7;
   localparam int CFG_AVG_BIT   = 0;
   localparam int CFG_START_BIT = 1;
   localparam int ENTRY_IDX_LSB = 4;
   localparam int ST_CHAN_LSB   = 4;
   localparam int ST_CNT_LSB    = 8;
   localparam int ST_RUN_BIT    = 13;
   localparam int ST_INT_BIT    = 14;

   typedef enum logic [3:0] {
      SCAN_NULL       = 4'h0,
      SCAN_MANUAL     = 4'h1,
      SCAN_REPEAT     = 4'h2,
      SCAN_STD_INT    = 4'h3,
      SCAN_STD_EXT    = 4'h4,
      SCAN_UPPER_INT  = 4'h5,
      SCAN_UPPER_EXT  = 4'h6,
      SCAN_CUSTOM_INT = 4'h7,
      SCAN_CUSTOM_EXT = 4'h8,
      SCAN_ARB        = 4'h9
   } asq_scan_type;

   localparam logic [3:0]  SCAN_LAST_VALID = 4'h9;
   localparam logic [3:0]  CHSEL_RST       = 4'h0;
   localparam logic [15:0] LIST_RST        = 16'h0000;
   localparam logic [7:0]  LEN_RST         = 8'h00;

   typedef enum logic [1:0] {
      RUN_IDLE = 2'b00,
      RUN_CONV = 2'b01
   } asq_run_type;

   typedef struct packed {
      logic       strobe;
      logic [3:0] chan;
      logic       int_clk;
      logic       avg;
   } asq_conv_type;
endpackage

// >>> asq_sequencer.sv
// scan-mode decoder and channel sequencer with apb registers
// Summary of operation
// - standard external: channels 0 up to N
// - upper internal: N to top, results counted
// - upper external: N to top, one per frame
// - custom internal: ascending list, at most 16
// - custom modes use list registers, averaging in custom internal
// - arbitrary sequence up to 256, external only
// - arbitrary entries in any order allowed
// - codes 1010 to 1111 change nothing
// - channel select is plain binary 0..15
// - internal modes run on internal tick
// - averaging only in internal modes
// - code 0000 changes nothing
//
// Our own choices: the APB register port and the register offsets.
module asq_sequencer
   import asq_pkg::*;
#(
   parameter int NUM_CH      = 16,
   parameter int CONV_CYCLES = 8,
   parameter int SEQ_DEPTH   = 256
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic [7:0]   paddr,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic         link_clk,
   input  wire logic         link_cs_n,
   output asq_conv_type      conv,
   output logic      [4:0]   fifo_count,
   output logic              run_busy
);
   localparam logic [3:0] TOP_CH = 4'(NUM_CH - 1);
   localparam logic [7:0] TICK_LAST = 8'(CONV_CYCLES - 1);

   // next set bit above c, wrapping to the lowest one
   function automatic logic [3:0] asc_next(input logic [15:0] m,
                                           input logic [3:0] c);
      logic [3:0] r;
      logic       hit;
      r = 4'h0;
      hit = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         if (m[i]) r = 4'(i);
      end
      for (int i = 0; i < 16; i++) begin
         if (!hit && m[i] && 4'(i) > c) begin
            r = 4'(i);
            hit = 1'b1;
         end
      end
      return r;
   endfunction

   function automatic logic [4:0] pop16(input logic [15:0] m);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < 16; i++) begin
         n = n + 5'(m[i]);
      end
      return n;
   endfunction

   // ---------------- link domain ----------------
   logic link_rst_meta_ff;
   logic link_rst_n_ff;
   logic frame_seen_ff;
   logic frame_tog_ff;

   always_ff @(posedge link_clk) begin
      link_rst_meta_ff <= rst_n;
      link_rst_n_ff    <= link_rst_meta_ff;
   end

   // cleared by the frame signal itself: the link clock may stop
   always_ff @(posedge link_clk or posedge link_cs_n) begin
      if (link_cs_n) frame_seen_ff <= 1'b0;
      else frame_seen_ff <= 1'b1;
   end

   always_ff @(posedge link_clk) begin
      if (!link_rst_n_ff) frame_tog_ff <= 1'b0;
      else if (!link_cs_n && !frame_seen_ff) frame_tog_ff <= ~frame_tog_ff;
   end

   // ---------------- crossing ----------------
   logic tog_meta_ff;
   logic tog_sync_ff;
   logic tog_prev_ff;
   wire  frame_evt = tog_sync_ff ^ tog_prev_ff;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tog_meta_ff <= 1'b0;
         tog_sync_ff <= 1'b0;
         tog_prev_ff <= 1'b0;
      end else begin
         tog_meta_ff <= frame_tog_ff;
         tog_sync_ff <= tog_meta_ff;
         tog_prev_ff <= tog_sync_ff;
      end
   end

   // ---------------- apb decode ----------------
   logic [3:0]  mode_ff;
   logic [3:0]  chsel_ff;
   logic [15:0] list_ff;
   logic [7:0]  len_ff;
   logic        avg_en_ff;
   logic [3:0]  seq_mem_ff [SEQ_DEPTH];
   logic [3:0]  chan_ff;
   logic [7:0]  idx_ff;
   logic        pending_ff;
   asq_run_type run_ff;
   logic [7:0]  tick_ff;
   logic [4:0]  done_cnt_ff;

   wire        apb_wr   = psel & penable & pready & pwrite;
   wire        setup    = psel & ~penable;
   wire [3:0]  wr_scan  = pwdata[SCAN_LSB +: 4];
   wire        is_cmd   = paddr == ADDR_CMD;
   wire        is_lo    = paddr == ADDR_LIST_LO;
   wire        is_hi    = paddr == ADDR_LIST_HI;
   wire        is_cfg   = paddr == ADDR_CFG;
   wire        is_len   = paddr == ADDR_SEQ_LEN;
   wire        is_ent   = paddr == ADDR_SEQ_ENTRY;
   wire        is_st    = paddr == ADDR_STATUS;
   wire        mapped   = is_cmd | is_lo | is_hi | is_cfg | is_len | is_ent | is_st;
   wire        cmd_mode = apb_wr & is_cmd & ~pwdata[CMD_SEL_BIT];
   // null codes keep mode and ignore the rest of the word
   wire        code_ok  = wr_scan != SCAN_NULL && wr_scan <= SCAN_LAST_VALID;
   wire        mode_wr  = cmd_mode & code_ok;
   wire        list_wr  = apb_wr & (is_lo | is_hi);
   wire        start_wr = apb_wr & is_cfg & pwdata[CFG_START_BIT];
   wire [7:0]  ent_idx  = pwdata[ENTRY_IDX_LSB +: 8];

   // ---------------- mode decode ----------------
   wire        m_int    = mode_ff == SCAN_STD_INT || mode_ff == SCAN_UPPER_INT ||
                          mode_ff == SCAN_CUSTOM_INT || mode_ff == SCAN_REPEAT;
   wire        m_ext    = mode_ff == SCAN_STD_EXT || mode_ff == SCAN_UPPER_EXT ||
                          mode_ff == SCAN_CUSTOM_EXT || mode_ff == SCAN_ARB ||
                          mode_ff == SCAN_MANUAL;
   wire        m_arb    = mode_ff == SCAN_ARB;
   wire [15:0] top_mask = 16'((32'h2 << TOP_CH) - 32'h1);
   wire [15:0] le_mask  = 16'((32'h2 << chsel_ff) - 32'h1);
   wire [15:0] lt_mask  = 16'((32'h1 << chsel_ff) - 32'h1);
   wire [15:0] one_mask = 16'(32'h1 << chsel_ff);
   wire [15:0] list_eff = list_ff & top_mask;
   logic [15:0] act_mask;

   always_comb begin
      case (mode_ff)
         SCAN_STD_INT,
         SCAN_STD_EXT:    act_mask = le_mask & top_mask;
         SCAN_UPPER_INT,
         SCAN_UPPER_EXT:  act_mask = top_mask & ~lt_mask;
         SCAN_CUSTOM_INT,
         SCAN_CUSTOM_EXT: act_mask = list_eff;
         default:         act_mask = one_mask;
      endcase
   end

   // ---------------- sequencing ----------------
   wire [3:0] first_ch = asc_next(act_mask, 4'hF);
   wire [3:0] cur_ch   = pending_ff ? first_ch : chan_ff;
   wire [7:0] cur_idx  = pending_ff ? 8'h00 : idx_ff;
   // arbitrary list has no order check at all
   wire [3:0] arb_ch   = seq_mem_ff[cur_idx];
   wire [3:0] conv_ch  = m_arb ? arb_ch : cur_ch;
   wire [3:0] nxt_chan = asc_next(act_mask, cur_ch);
   wire [7:0] nxt_idx  = (cur_idx == len_ff) ? 8'h00 : cur_idx + 8'h01;
   wire [4:0] total    = (mode_ff == SCAN_REPEAT) ? 5'h01 : pop16(act_mask);
   wire       tick_end = run_ff == RUN_CONV && tick_ff == TICK_LAST;
   wire       run_last = tick_end && done_cnt_ff + 5'h01 >= total;
   wire       ext_step = frame_evt & m_ext & ~mode_wr;
   wire       int_step = tick_end;
   wire       step     = ext_step | int_step;
   wire       int_go   = start_wr & m_int & (total != 5'h00);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mode_ff  <= SCAN_NULL;
         chsel_ff <= CHSEL_RST;
      end else if (mode_wr) begin
         mode_ff  <= wr_scan;
         chsel_ff <= pwdata[CHSEL_LSB +: 4];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         list_ff   <= LIST_RST;
         len_ff    <= LEN_RST;
         avg_en_ff <= 1'b0;
      end else begin
         if (apb_wr & is_lo) list_ff[7:0] <= pwdata[7:0];
         if (apb_wr & is_hi) list_ff[15:8] <= pwdata[7:0];
         if (apb_wr & is_len) len_ff <= pwdata[7:0];
         if (apb_wr & is_cfg) avg_en_ff <= pwdata[CFG_AVG_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < SEQ_DEPTH; i++) seq_mem_ff[i] <= 4'h0;
      end else if (apb_wr & is_ent) begin
         seq_mem_ff[ent_idx] <= pwdata[3:0];
      end
   end

   // a new mode or list restarts from its first entry
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         chan_ff    <= 4'h0;
         idx_ff     <= 8'h00;
         pending_ff <= 1'b1;
      end else if (mode_wr | list_wr | int_go) begin
         pending_ff <= 1'b1;
      end else if (step) begin
         chan_ff    <= nxt_chan;
         idx_ff     <= nxt_idx;
         pending_ff <= run_last;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         run_ff      <= RUN_IDLE;
         tick_ff     <= 8'h00;
         done_cnt_ff <= 5'h00;
      end else if (int_go) begin
         run_ff      <= RUN_CONV;
         tick_ff     <= 8'h00;
         done_cnt_ff <= 5'h00;
      end else if (mode_wr) begin
         run_ff <= RUN_IDLE;
      end else if (run_ff == RUN_CONV) begin
         tick_ff <= tick_end ? 8'h00 : tick_ff + 8'h01;
         if (tick_end) done_cnt_ff <= done_cnt_ff + 5'h01;
         if (run_last) run_ff <= RUN_IDLE;
      end
   end

   // ---------------- outputs ----------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         conv       <= '0;
         fifo_count <= 5'h00;
         run_busy   <= 1'b0;
      end else begin
         conv.strobe  <= step;
         conv.chan    <= step ? conv_ch : conv.chan;
         conv.int_clk <= m_int;
         conv.avg     <= m_int & avg_en_ff;
         fifo_count   <= int_go ? 5'h00 :
                         tick_end ? done_cnt_ff + 5'h01 : fifo_count;
         run_busy     <= run_ff == RUN_CONV && !run_last;
      end
   end

   // ---------------- apb read ----------------
   logic [31:0] rd_word;

   always_comb begin
      rd_word = 32'h0000_0000;
      case (1'b1)
         is_cmd:  rd_word = {16'h0000, 1'b0, mode_ff, chsel_ff, 7'h00};
         is_lo:   rd_word = {24'h000000, list_ff[7:0]};
         is_hi:   rd_word = {24'h000000, list_ff[15:8]};
         is_cfg:  rd_word = {31'h0, avg_en_ff};
         is_len:  rd_word = {24'h000000, len_ff};
         is_st: begin
            rd_word[3:0]                = mode_ff;
            rd_word[ST_CHAN_LSB +: 4]   = conv.chan;
            rd_word[ST_CNT_LSB +: 5]    = fifo_count;
            rd_word[ST_RUN_BIT]         = run_busy;
            rd_word[ST_INT_BIT]         = m_int;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // one setup cycle loads the answer, access completes at once
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         prdata  <= (setup & ~pwrite) ? rd_word : 32'h0000_0000;
      end
   end
endmodule

// >>> asq_checker.sv
// port assertions for the scan sequencer
module asq_checker
   import asq_pkg::*;
#(
   parameter int NUM_CH = 16
) (
   input wire logic         ref_clk,
   input wire logic         rst_n,
   input wire logic [7:0]   paddr,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic [31:0]  prdata,
   input wire logic         pready,
   input wire logic         pslverr,
   input wire asq_conv_type conv,
   input wire logic         run_busy
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire mapped = (paddr <= 8'h18) && (paddr[1:0] == 2'h0);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   property p_ready; s_setup |=> s_access; endproperty
   property p_idle; !psel |=> !pready; endproperty
   property p_err; pready |-> pslverr == !mapped; endproperty
   property p_rdzero; !pready |-> prdata == 32'h0; endproperty
   property p_pulse; conv.strobe |=> !conv.strobe; endproperty
   property p_hold; $changed(conv.chan) |-> conv.strobe; endproperty
   property p_range; conv.strobe |-> conv.chan < NUM_CH; endproperty
   property p_avg; conv.avg |-> conv.int_clk; endproperty
   property p_busy; run_busy |-> conv.int_clk; endproperty
   a_ready: assert property (p_ready) else $error("no access answer");
   a_idle: assert property (p_idle) else $error("pready without setup");
   a_err: assert property (p_err) else $error("pslverr wrong");
   a_rdzero: assert property (p_rdzero) else $error("prdata not zero");
   a_pulse: assert property (p_pulse) else $error("strobe too long");
   a_hold: assert property (p_hold) else $error("chan moved alone");
   a_range: assert property (p_range) else $error("chan beyond top");
   a_avg: assert property (p_avg) else $error("avg in external");
   a_busy: assert property (p_busy) else $error("run not internal");
endmodule
bind asq_sequencer asq_checker #(.NUM_CH(NUM_CH)) u_chk (
   .ref_clk, .rst_n, .paddr, .psel, .penable, .prdata, .pready, .pslverr, .conv, .run_busy
);

// >>> asq_host_model.sv
// serial host model: frames on the link clock
module asq_host_model (
   output logic link_clk,
   output logic link_cs_n
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      link_clk = 1'b0;
      link_cs_n = 1'b1;
   end
   // 80 ns link clock, still between frames
   task automatic pulse();
      #13 link_clk = 1'b1;
      #40 link_clk = 1'b0;
      #27;
   endtask
   // host supplies the timing of external scans
   task automatic frame();
      link_cs_n = 1'b0;
      pulse();
      link_cs_n = 1'b1;
      #40;
   endtask
endmodule

// >>> testbench.sv
// self-checking bench for the scan sequencer
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import asq_pkg::*;
   logic         ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
   logic         link_clk, link_cs_n, run_busy;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, rd;
   logic [4:0]   fifo_count;
   asq_conv_type conv;
   int           miscompares = 0;
   int           checks = 0;
   asq_sequencer #(.NUM_CH(16), .CONV_CYCLES(4), .SEQ_DEPTH(256)) dut (
      .ref_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .link_clk, .link_cs_n, .conv, .fifo_count, .run_busy);
   asq_host_model host (.link_clk, .link_cs_n);
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic test_done();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // a wait that ran out is a mismatch and ends the run
   task automatic give_up(input string what);
      miscompares++;
      $display("CHECK FAILED t=%0t %s timed out", $time, what);
      test_done();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         give_up("apb ready");
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic mode(input logic [3:0] c, input logic [3:0] n);
      apb(1'b1, ADDR_CMD, {16'h0, 1'b0, c, n, 7'h0});
   endtask
   // one frame, then the step it causes
   task automatic steps(input logic [3:0] q[]);
      int n;
      foreach (q[i]) begin
         fork
            host.frame();
            begin
               n = 0;
               do begin
                  @(negedge ref_clk);
                  n++;
               end while (conv.strobe !== 1'b1 && n < 40);
            end
         join
         if (n >= 40) begin
            give_up("frame step");
         end
         chk({26'h0, conv.int_clk, conv.avg, conv.chan}, {26'h0, 2'b00, q[i]});
      end
   endtask
   task automatic t_int(input logic [3:0] c, input logic [3:0] n, input int exp);
      int k;
      int cnt;
      logic seen;
      logic [3:0] first_ch;
      logic [3:0] last_ch;
      cnt = 0;
      seen = 1'b0;
      first_ch = 4'h0;
      last_ch = 4'h0;
      mode(c, n);
      apb(1'b1, ADDR_CFG, 32'h3);
      for (k = 0; k < 400; k++) begin
         @(negedge ref_clk);
         if (conv.strobe === 1'b1) begin
            if (cnt == 0) first_ch = conv.chan;
            last_ch = conv.chan;
            cnt++;
            chk({30'h0, conv.int_clk, conv.avg}, 32'h3);
         end
         if (run_busy === 1'b1) seen = 1'b1;
         else if (seen) break;
      end
      if (k >= 400) begin
         give_up("internal run");
      end
      chk(cnt, exp);
      chk({27'h0, fifo_count}, exp);
      // both internal scans here start at N and end on the top channel
      chk({28'h0, first_ch}, {28'h0, n});
      chk({28'h0, last_ch}, 32'hF);
   endtask
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge ref_clk);
      // link side resets from a synced copy, needs link edges
      repeat (3) host.pulse();
      @(posedge ref_clk);
      rst_n <= 1'b1;
      // link reset sync lets go only after two more link edges
      repeat (2) host.pulse();
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h1C, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, ADDR_LIST_LO, 32'h05);
      apb(1'b1, ADDR_LIST_HI, 32'h80);
      t_int(SCAN_UPPER_INT, 4'hC, 4);
      t_int(SCAN_CUSTOM_INT, 4'h0, 3);
      mode(SCAN_STD_EXT, 4'h3);
      apb(1'b0, ADDR_CMD, 32'h0);
      chk(rd, 32'h2180);
      steps('{4'h0, 4'h1, 4'h2, 4'h3, 4'h0});
      for (int c = 10; c < 16; c++) mode(c[3:0], 4'h9);
      mode(SCAN_NULL, 4'h9);
      apb(1'b1, ADDR_CMD, 32'h0000B480);
      apb(1'b0, ADDR_CMD, 32'h0);
      chk(rd, 32'h2180);
      mode(SCAN_UPPER_EXT, 4'hE);
      steps('{4'hE, 4'hF, 4'hE});
      mode(SCAN_CUSTOM_EXT, 4'h0);
      steps('{4'h0, 4'h2, 4'hF, 4'h0});
      apb(1'b1, ADDR_SEQ_LEN, 32'h3);
      apb(1'b1, ADDR_SEQ_ENTRY, 32'h009);
      apb(1'b1, ADDR_SEQ_ENTRY, 32'h012);
      apb(1'b1, ADDR_SEQ_ENTRY, 32'h022);
      apb(1'b1, ADDR_SEQ_ENTRY, 32'h037);
      mode(SCAN_ARB, 4'h0);
      steps('{4'h9, 4'h2, 4'h2, 4'h7, 4'h9});
      test_done();
   end
endmodule
